// *** slcdfc_regs.svh ***
`ifndef SLCDFC_REGS_SVH
`define SLCDFC_REGS_SVH

// ----------------------------------------------------------------------
// Field encodings.
// ----------------------------------------------------------------------
`define SLCDFC_DUTY_STATIC 2'h0
`define SLCDFC_DUTY_HALF 2'h1
`define SLCDFC_DUTY_THIRD 2'h2
`define SLCDFC_DUTY_QUARTER 2'h3
`define SLCDFC_BIAS_THIRD 1'h0
`define SLCDFC_BIAS_HALF 1'h1
`define SLCDFC_CLK_SYNC 1'h0
`define SLCDFC_CLK_ASYNC 1'h1

// ----------------------------------------------------------------------
// Geometry and reset values.
// ----------------------------------------------------------------------
`define SLCDFC_NUM_SEG 25
`define SLCDFC_NUM_COM 4
`define SLCDFC_MEM_BITS 100
`define SLCDFC_CONTRAST_W 8
`define SLCDFC_CONTRAST_RST 8'h00
`define SLCDFC_SEG_EN_RST 25'h000_0000
`define SLCDFC_COM_EN_RST 4'h0

`endif

// *** slcdfc_pkg.sv ***
package slcdfc_pkg;
  typedef logic [1:0] slcdfc_duty_t;
  typedef logic [2:0] slcdfc_pmask_t;
  typedef logic [3:0] slcdfc_com_t;
  typedef logic [24:0] slcdfc_seg_t;
  typedef enum logic [2:0] {
    SLCDFC_OFF = 3'b001,
    SLCDFC_DRIVE = 3'b010,
    SLCDFC_BLANK = 3'b100
  } slcdfc_state_t;
endpackage

// *** slcdfc_pin_if.sv ***
`timescale 1ns/1ps
interface slcdfc_pin_if;
  logic [1:0] duty;
  logic [2:0] port_mask;
  logic enable;
  logic [24:0] seg_en;
  logic [3:0] com_en;
  modport ctrl (output duty, output port_mask, output enable,
    input seg_en, input com_en);
  modport map (input duty, input port_mask, input enable,
    output seg_en, output com_en);
endinterface

// *** slcdfc_pin_map.sv ***
`timescale 1ns/1ps
`include "slcdfc_regs.svh"
module slcdfc_pin_map (
  slcdfc_pin_if.map pins
);
  import slcdfc_pkg::*;

  function automatic slcdfc_seg_t seg_mask(input slcdfc_pmask_t pm);
    case (pm)
      3'h0: seg_mask = 25'h000_1FFF;
      3'h1: seg_mask = 25'h000_7FFF;
      3'h2: seg_mask = 25'h001_FFFF;
      3'h3: seg_mask = 25'h007_FFFF;
      3'h4: seg_mask = 25'h01F_FFFF;
      3'h5: seg_mask = 25'h07F_FFFF;
      3'h6: seg_mask = 25'h0FF_FFFF;
      default: seg_mask = 25'h1FF_FFFF;
    endcase
  endfunction

  function automatic slcdfc_com_t com_mask(input slcdfc_duty_t d);
    case (d)
      `SLCDFC_DUTY_STATIC: com_mask = 4'h1;
      `SLCDFC_DUTY_HALF: com_mask = 4'h3;
      `SLCDFC_DUTY_THIRD: com_mask = 4'h7;
      default: com_mask = 4'hF;
    endcase
  endfunction

  assign pins.seg_en = pins.enable ? seg_mask(pins.port_mask)
                                   : `SLCDFC_SEG_EN_RST;
  assign pins.com_en = pins.enable ? com_mask(pins.duty)
                                   : `SLCDFC_COM_EN_RST;
endmodule

// *** slcdfc_frame_ctl.sv ***
`timescale 1ns/1ps
`include "slcdfc_regs.svh"
// What this block does
// - Static, two, three, four common duties.
// - Half or third bias for multiplexed duties.
// - Low-power bit selects reduced-toggle waveform.
// - Low-power mode latches once per frame pair.
// - Sync clock keeps refreshing in idle, power-save.
// - Async clock runs in three sleep modes.
// - External clock option enables input buffer only with async clock selected.
// - Blanking finishes frame then grounds pins.
// - Blanking keeps display memory unchanged.
// - Port mask frees unused segment pins.
// - Contrast changes accepted while running.
// - Memory, contrast, low-power latched at frame start; duty, bias each clock.
// - Writes accepted any time; may split.
// - Mask code 100 drives segments 0-20.
// - Duty field encodes one to four commons.
// - Bias bit zero third, one half.
// - Frame flag set at frame start; every second frame in low power.
// - Clock select zero system, one async.
module slcdfc_frame_ctl #(
  parameter int NUM_SEG = `SLCDFC_NUM_SEG,
  parameter int MEM_BITS = `SLCDFC_MEM_BITS,
  parameter int CONTRAST_W = `SLCDFC_CONTRAST_W
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_controller_enable,
  input wire logic i_low_power_wave_sel,
  input wire logic i_blanking_ctl,
  input wire logic i_half_bias_sel,
  input wire slcdfc_pkg::slcdfc_duty_t i_duty_sel,
  input wire slcdfc_pkg::slcdfc_pmask_t i_port_mask,
  input wire logic i_clock_source_sel,
  input wire logic i_external_clock_enable,
  input wire logic [CONTRAST_W-1:0] i_contrast_ctl_reg,
  input wire logic [MEM_BITS-1:0] i_display_mem_reg,
  input wire logic i_frame_tick,
  input wire logic i_frame_irq_clear,
  input wire logic i_sleep_idle,
  input wire logic i_sleep_power_save,
  input wire logic i_sleep_adc_nr,
  input wire logic i_sleep_deep,
  output logic [MEM_BITS-1:0] o_latched_mem,
  output logic [CONTRAST_W-1:0] o_latched_contrast,
  output logic o_latched_low_power,
  output logic o_latched_half_bias,
  output slcdfc_pkg::slcdfc_duty_t o_latched_duty,
  output logic o_blanked,
  output logic o_driving,
  output logic o_frame_irq_flag,
  output logic o_frame_parity,
  output logic o_use_async_clk,
  output logic o_ext_clk_buf_en,
  output logic o_lcd_clk_run,
  output slcdfc_pkg::slcdfc_seg_t o_seg_lcd_en,
  output slcdfc_pkg::slcdfc_com_t o_com_lcd_en
);
  import slcdfc_pkg::*;

  // ----------------------------------------------------------------------
  // Frame sequencing.
  // ----------------------------------------------------------------------
  slcdfc_state_t state_reg;
  slcdfc_state_t state_next;
  logic latch_now;
  logic blank_next;
  slcdfc_pin_if pins ();

  assign latch_now = i_controller_enable && i_frame_tick &&
    (!o_latched_low_power || !o_frame_parity);
  assign blank_next = latch_now ? i_blanking_ctl : o_blanked;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLCDFC_OFF: begin
        if (i_controller_enable && latch_now && i_blanking_ctl) begin
          state_next = SLCDFC_BLANK;
        end else if (i_controller_enable) begin
          state_next = SLCDFC_DRIVE;
        end
      end
      SLCDFC_DRIVE: begin
        if (!i_controller_enable) begin
          state_next = SLCDFC_OFF;
        end else if (latch_now && i_blanking_ctl) begin
          state_next = SLCDFC_BLANK;
        end
      end
      SLCDFC_BLANK: begin
        if (!i_controller_enable) begin
          state_next = SLCDFC_OFF;
        end else if (latch_now && !i_blanking_ctl) begin
          state_next = SLCDFC_DRIVE;
        end
      end
      default: begin
        state_next = SLCDFC_OFF;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= SLCDFC_OFF;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Frame parity.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frame_parity <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_controller_enable) begin
        o_frame_parity <= 1'b0;
      end else if (i_frame_tick) begin
        o_frame_parity <= latch_now ? i_low_power_wave_sel : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Working latches.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_latched_mem <= '0;
      o_latched_contrast <= `SLCDFC_CONTRAST_RST;
      o_latched_low_power <= 1'b0;
      o_latched_half_bias <= `SLCDFC_BIAS_THIRD;
      o_latched_duty <= `SLCDFC_DUTY_STATIC;
      o_blanked <= 1'b0;
    end else if (i_clk_en) begin
      if (latch_now) begin
        o_latched_mem <= i_display_mem_reg;
        o_latched_contrast <= i_contrast_ctl_reg;
        o_latched_low_power <= i_low_power_wave_sel;
      end
      o_latched_duty <= i_duty_sel;
      o_latched_half_bias <= (i_duty_sel == `SLCDFC_DUTY_STATIC) ?
        `SLCDFC_BIAS_THIRD : i_half_bias_sel;
      o_blanked <= i_controller_enable && blank_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_driving <= 1'b0;
    end else if (i_clk_en) begin
      o_driving <= state_next == SLCDFC_DRIVE;
    end
  end

  // ----------------------------------------------------------------------
  // Frame flag.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frame_irq_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (latch_now) begin
        o_frame_irq_flag <= 1'b1;
      end else if (i_frame_irq_clear) begin
        o_frame_irq_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock source and sleep.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_use_async_clk <= `SLCDFC_CLK_SYNC;
      o_ext_clk_buf_en <= 1'b0;
      o_lcd_clk_run <= 1'b0;
    end else if (i_clk_en) begin
      o_use_async_clk <= i_clock_source_sel;
      o_ext_clk_buf_en <= i_clock_source_sel && i_external_clock_enable;
      if (!i_controller_enable || i_sleep_deep) begin
        o_lcd_clk_run <= 1'b0;
      end else if (i_sleep_idle || i_sleep_power_save) begin
        o_lcd_clk_run <= 1'b1;
      end else if (i_sleep_adc_nr) begin
        o_lcd_clk_run <= i_clock_source_sel;
      end else begin
        o_lcd_clk_run <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin ownership.
  // ----------------------------------------------------------------------
  assign pins.duty = i_duty_sel;
  assign pins.port_mask = i_port_mask;
  assign pins.enable = i_controller_enable;

  slcdfc_pin_map u_map (
    .pins(pins)
  );

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_seg_lcd_en <= `SLCDFC_SEG_EN_RST;
      o_com_lcd_en <= `SLCDFC_COM_EN_RST;
    end else if (i_clk_en) begin
      o_seg_lcd_en <= pins.seg_en;
      o_com_lcd_en <= pins.com_en;
    end
  end
endmodule

// *** slcdfc_glass.sv ***
`timescale 1ns/1ps
module slcdfc_glass (
  input wire logic i_mclk,
  input wire logic i_driving,
  input wire logic i_blanked,
  output logic o_dark
);
  always_ff @(posedge i_mclk) begin
    o_dark <= i_blanked || !i_driving;
  end
endmodule

// *** slcdfc_chk.sv ***
`timescale 1ns/1ps
module slcdfc_chk #(
  parameter int MEM_BITS = 100
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_controller_enable,
  input wire logic i_blanking_ctl,
  input wire slcdfc_pkg::slcdfc_duty_t i_duty_sel,
  input wire slcdfc_pkg::slcdfc_pmask_t i_port_mask,
  input wire logic [MEM_BITS-1:0] i_display_mem_reg,
  input wire logic i_frame_tick,
  input wire logic i_frame_irq_clear,
  input wire logic [MEM_BITS-1:0] o_latched_mem,
  input wire logic o_latched_low_power,
  input wire logic o_blanked,
  input wire logic o_frame_irq_flag,
  input wire logic o_frame_parity,
  input wire slcdfc_pkg::slcdfc_seg_t o_seg_lcd_en,
  input wire slcdfc_pkg::slcdfc_com_t o_com_lcd_en
);
  import slcdfc_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic run_ok;
  logic take;
  logic skip;
  assign run_ok = i_clk_en && i_controller_enable;
  assign take = run_ok && i_frame_tick
    && !(o_latched_low_power && o_frame_parity);
  assign skip = run_ok && i_frame_tick && o_latched_low_power
    && o_frame_parity;
  latch_data_a: assert property (
    take |=> o_latched_mem == $past(i_display_mem_reg))
    else $error("latched memory differs from input");
  flag_set_a: assert property (
    take |=> o_frame_irq_flag) else $error("frame flag not set");
  flag_clear_a: assert property (
    i_clk_en && i_frame_irq_clear && !i_frame_tick |=> !o_frame_irq_flag)
    else $error("frame flag not cleared");
  pair_skip_a: assert property (
    skip |=> $stable(o_latched_mem)) else $error("second frame latched");
  off_pins_a: assert property (
    i_clk_en && !i_controller_enable |=> o_seg_lcd_en == '0
    && o_com_lcd_en == '0) else $error("pins kept while disabled");
  mask_code_a: assert property (
    run_ok && i_port_mask == 3'h4 |=> o_seg_lcd_en == 25'h1F_FFFF)
    else $error("segment mask wrong");
  com_duty_a: assert property (
    run_ok |=> o_com_lcd_en == 4'hF >> (2'h3 - $past(i_duty_sel)))
    else $error("common pins wrong for duty");
  blank_latch_a: assert property (
    take |=> o_blanked == $past(i_blanking_ctl))
    else $error("blanking not latched");
  cover property (take && o_latched_low_power);
  cover property (skip);
  cover property (take && i_blanking_ctl);
endmodule
bind slcdfc_frame_ctl slcdfc_chk #(.MEM_BITS(MEM_BITS)) u_slcdfc_chk (
  .i_mclk(i_mclk),
  .i_reset_n(i_reset_n),
  .i_clk_en(i_clk_en),
  .i_controller_enable(i_controller_enable),
  .i_blanking_ctl(i_blanking_ctl),
  .i_duty_sel(i_duty_sel),
  .i_port_mask(i_port_mask),
  .i_display_mem_reg(i_display_mem_reg),
  .i_frame_tick(i_frame_tick),
  .i_frame_irq_clear(i_frame_irq_clear),
  .o_latched_mem(o_latched_mem),
  .o_latched_low_power(o_latched_low_power),
  .o_blanked(o_blanked),
  .o_frame_irq_flag(o_frame_irq_flag),
  .o_frame_parity(o_frame_parity),
  .o_seg_lcd_en(o_seg_lcd_en),
  .o_com_lcd_en(o_com_lcd_en)
);

// *** slcdfc_frame_ctl_tb.sv ***
`timescale 1ns/1ps
module slcdfc_frame_ctl_tb;
  import slcdfc_pkg::*;
  logic clk, rst_n, ce, en, lp, bl, hb, cs, ext, tick, clr;
  logic idle, ps, adc, deep, l_lp, l_hb, blk, drv, flag, par;
  logic use_a, buf_en, run, dark;
  slcdfc_duty_t duty, l_duty;
  slcdfc_pmask_t pm;
  slcdfc_seg_t seg_en;
  slcdfc_com_t com_en;
  logic [7:0] con, l_con;
  logic [99:0] mem, l_mem;
  int fail_count, n_checks;
  int segs[8] = '{13, 15, 17, 19, 21, 23, 24, 25};
  logic [5:0] ck_in[5] = '{6'h18, 6'h04, 6'h32, 6'h24, 6'h21};
  logic [2:0] ck_ex[5] = '{3'h1, 3'h1, 3'h7, 3'h5, 3'h4};
  slcdfc_frame_ctl u_slcdfc_frame_ctl (
    .i_mclk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
    .i_controller_enable(en), .i_low_power_wave_sel(lp),
    .i_blanking_ctl(bl), .i_half_bias_sel(hb), .i_duty_sel(duty),
    .i_port_mask(pm), .i_clock_source_sel(cs),
    .i_external_clock_enable(ext), .i_contrast_ctl_reg(con),
    .i_display_mem_reg(mem), .i_frame_tick(tick),
    .i_frame_irq_clear(clr), .i_sleep_idle(idle),
    .i_sleep_power_save(ps), .i_sleep_adc_nr(adc), .i_sleep_deep(deep),
    .o_latched_mem(l_mem), .o_latched_contrast(l_con),
    .o_latched_low_power(l_lp), .o_latched_half_bias(l_hb),
    .o_latched_duty(l_duty), .o_blanked(blk), .o_driving(drv),
    .o_frame_irq_flag(flag), .o_frame_parity(par),
    .o_use_async_clk(use_a), .o_ext_clk_buf_en(buf_en),
    .o_lcd_clk_run(run), .o_seg_lcd_en(seg_en), .o_com_lcd_en(com_en)
  );
  slcdfc_glass u_slcdfc_glass (.i_mclk(clk), .i_driving(drv),
    .i_blanked(blk), .o_dark(dark));
  task automatic chk(input string n, input logic [99:0] e, s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(ref logic sig);
    @(negedge clk) sig = 1;
    @(negedge clk) sig = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1ms;
    fail_count++;
    stop_test();
  end
  initial begin
    {rst_n, en, lp, bl, hb, cs, ext, tick, clr, idle, ps} = '0;
    {adc, deep, duty, pm, con, mem} = '0;
    ce = 1;
    repeat (12) @(negedge clk);
    rst_n = 1;
    chk("flag", 0, flag);
    {duty, pm, con} = {2'h3, 3'h7, 8'h5a};
    en = 1;
    hb = 1;
    for (int d = 0; d < 4; d++) begin
      duty = d[1:0];
      repeat (2) @(negedge clk);
      chk("com_en", 4'hf >> (3 - d), com_en);
      chk("duty", d, l_duty);
      chk("half_bias", d != 0, l_hb);
    end
    hb = 0;
    repeat (2) @(negedge clk);
    chk("half_bias", 0, l_hb);
    for (int m = 0; m < 8; m++) begin
      pm = m[2:0];
      repeat (2) @(negedge clk);
      chk("seg_en", (100'h1 << segs[m]) - 1, seg_en);
    end
    $display("test pins done");
    mem = 100'h1234_5678;
    pulse(tick);
    chk("mem", mem, l_mem);
    chk("contrast", con, l_con);
    chk("flag", 1, flag);
    {mem, con} = {100'h9, 8'hc3};
    pulse(clr);
    chk("flag", 0, flag);
    chk("mem", 100'h1234_5678, l_mem);
    pulse(tick);
    chk("contrast", 8'hc3, l_con);
    chk("mem", 100'h9, l_mem);
    bl = 1;
    repeat (2) @(negedge clk);
    chk("blanked", 0, blk);
    pulse(tick);
    chk("blanked", 1, blk);
    chk("dark", 1, dark);
    chk("driving", 0, drv);
    chk("mem", 100'h9, l_mem);
    pulse(tick);
    chk("blanked", 1, blk);
    bl = 0;
    pulse(tick);
    chk("blanked", 0, blk);
    chk("dark", 0, dark);
    chk("driving", 1, drv);
    $display("test frames done");
    {lp, mem} = {1'b1, 100'ha};
    pulse(tick);
    chk("low_power", 1, l_lp);
    chk("parity", 1, par);
    pulse(clr);
    mem = 100'hb;
    pulse(tick);
    chk("mem", 100'ha, l_mem);
    chk("flag", 0, flag);
    chk("parity", 0, par);
    pulse(tick);
    chk("mem", 100'hb, l_mem);
    chk("flag", 1, flag);
    lp = 0;
    pulse(tick);
    pulse(tick);
    chk("low_power", 0, l_lp);
    $display("test low power done");
    // no deep sleep on the system clock while enabled
    for (int k = 0; k < 5; k++) begin
      {cs, ext, idle, ps, adc, deep} = ck_in[k];
      repeat (2) @(negedge clk);
      chk("clock", ck_ex[k], {use_a, buf_en, run});
    end
    {cs, ext, idle, ps, adc, deep} = 6'h00;
    $display("test clock done");
    bl = 1;
    pulse(tick);
    pulse(clr);
    en = 0;
    repeat (2) @(negedge clk);
    chk("seg_en", 0, seg_en);
    chk("com_en", 0, com_en);
    pulse(tick);
    chk("flag", 0, flag);
    {duty, pm, bl} = {2'h1, 3'h4, 1'b0};
    repeat (2) @(negedge clk);
    en = 1;
    repeat (2) @(negedge clk);
    chk("com_en", 4'h3, com_en);
    chk("seg_en", 25'h01F_FFFF, seg_en);
    chk("driving", 1, drv);
    $display("test disable done");
    stop_test();
  end
endmodule
